// File: shared/vsg_pkg.sv
// Purpose: constants and carrier types for the video sync timing generator
// Assumes: 12-bit timing registers, 6-bit register address
// Notes:   indices 0..18 are the only writable registers
package vsg_pkg;

   localparam int unsigned REG_W     = 12;
   localparam int unsigned ADDR_W    = 6;
   localparam int unsigned NUM_REGS  = 19;
   localparam int unsigned CNT_W     = 13;

   // register indices
   localparam logic [ADDR_W-1:0] ADR_STATUS       = 6'h00;
   localparam logic [ADDR_W-1:0] ADR_H_FRONT      = 6'h01;
   localparam logic [ADDR_W-1:0] ADR_H_SYNC_END   = 6'h02;
   localparam logic [ADDR_W-1:0] ADR_H_BLANK_END  = 6'h03;
   localparam logic [ADDR_W-1:0] ADR_H_TOTAL      = 6'h04;
   localparam logic [ADDR_W-1:0] ADR_V_FRONT      = 6'h05;
   localparam logic [ADDR_W-1:0] ADR_V_SYNC_END   = 6'h06;
   localparam logic [ADDR_W-1:0] ADR_V_BLANK_END  = 6'h07;
   localparam logic [ADDR_W-1:0] ADR_V_TOTAL      = 6'h08;
   localparam logic [ADDR_W-1:0] ADR_EQ_END       = 6'h09;
   localparam logic [ADDR_W-1:0] ADR_SERR_END     = 6'h0a;
   localparam logic [ADDR_W-1:0] ADR_ES_WIN_START = 6'h0b;
   localparam logic [ADDR_W-1:0] ADR_ES_WIN_END   = 6'h0c;
   localparam logic [ADDR_W-1:0] ADR_VINT_ON      = 6'h0d;
   localparam logic [ADDR_W-1:0] ADR_VINT_OFF     = 6'h0e;
   localparam logic [ADDR_W-1:0] ADR_CUR_H_START  = 6'h0f;
   localparam logic [ADDR_W-1:0] ADR_CUR_H_END    = 6'h10;
   localparam logic [ADDR_W-1:0] ADR_CUR_V_START  = 6'h11;
   localparam logic [ADDR_W-1:0] ADR_CUR_V_END    = 6'h12;
   localparam logic [ADDR_W-1:0] ADR_LAST         = 6'h12;

   // status register fields
   localparam int unsigned ST_SEL_V_BLANK = 0;
   localparam int unsigned ST_SEL_V_SYNC  = 1;
   localparam int unsigned ST_SEL_CURSOR  = 2;
   localparam int unsigned ST_MODE_LO     = 3;
   localparam int unsigned ST_MODE_HI     = 4;
   localparam int unsigned ST_POL_BLANK   = 5;
   localparam int unsigned ST_POL_SYNC    = 6;
   localparam int unsigned ST_POL_HAUX    = 7;
   localparam int unsigned ST_POL_VAUX    = 8;
   localparam int unsigned ST_ES_OFF      = 9;
   localparam int unsigned ST_RUN         = 10;

   // reset values
   localparam logic [REG_W-1:0]  STATUS_RST = 12'h000;
   localparam logic [REG_W-1:0]  DATA_RST   = 12'h000;
   localparam logic [CNT_W-1:0]  CNT_RST    = 13'h0000;
   localparam logic [4:0]        OUT_RST    = 5'h1f;

   typedef struct packed {
      logic [1:0] load;
      logic [1:0] ad;
      logic [1:0] bh;
      logic [7:0] d1;
      logic [7:0] d2;
   } vsg_sync_t;

   typedef struct packed {
      logic blank;
      logic sync;
      logic haux;
      logic vaux;
      logic odd;
   } vsg_out_t;

   typedef struct packed {
      logic h_blank;
      logic h_sync;
      logic h_gate;
      logic eq;
      logic serr;
      logic v_blank;
      logic v_sync;
      logic v_int;
      logic v_gate;
      logic es_win;
   } vsg_pulse_t;

endpackage

// File: verilog/vsg_timing.sv
// Purpose: programmable raster sync/blank generator with byte-wide load port
// Assumes: load port pins are asynchronous to CLOCK and held around load edges
// Notes:   all state advances on the falling edge of CLOCK
//
// How it works
// - horizontal count runs 1 up to line total
// - horizontal outputs change on falling clock edge
// - line, blank, sync, porch widths follow registers
// - interlaced vertical timing counts half-lines
// - frame total is whole lines, no extra
// - vertical count runs 1 up to frame total
// - vertical blank/sync move on horizontal leading edges
// - frame, field, vertical blank/sync widths follow registers
// - composite signals combine vertical and horizontal parts
// - serration replaces vsync inside equalization window
// - equalization width is equalization_pulse_end minus reg1
// - serration width from line, reg1, serration_pulse_end
// - gating pulses when composite and cursor bit clear
// - cursor pulse is horizontal and vertical gating
// - vertical interrupt spans vert_interrupt_on_line to vert_interrupt_off_line lines
// - auto mode increments address after high byte
// - address wraps to start after last register
// - auto addressing starts on address cycle, byte one
// - selects on load fall, data on load rise
// - every timing register holds twelve bits
// - status bit nine suppresses equalization and serration
`timescale 1ns/1ps
`default_nettype none

module vsg_timing (
   // clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RESET,
   input  wire logic       CLK_EN,
   // load port
   input  wire logic       LOAD,
   input  wire logic       ADDR_OR_DATA_SELECT,
   input  wire logic       BYTE_HALF_SELECT,
   input  wire logic [7:0] DATA,
   // video outputs
   output logic            BLANK_OUT,
   output logic            SYNC_OUT,
   output logic            HORIZ_AUX_OUT,
   output logic            VERT_AUX_OUT,
   output logic            FIELD_ODD_OUT
);

   typedef struct packed {
      vsg_pkg::vsg_sync_t                                  sy;
      logic                                                ad_lat;
      logic                                                bh_lat;
      logic                                                auto_on;
      logic                                                load_q;
      logic [vsg_pkg::ADDR_W-1:0]                          addr;
      logic [vsg_pkg::ADDR_W-1:0]                          start;
      logic [vsg_pkg::NUM_REGS-1:0][vsg_pkg::REG_W-1:0]    regs;
      logic [vsg_pkg::REG_W-1:0]                           hcnt;
      logic [vsg_pkg::CNT_W-1:0]                           vcnt;
      vsg_pkg::vsg_pulse_t                                 p;
      vsg_pkg::vsg_out_t                                   o;
   } vsg_state_t;

   vsg_state_t s_r;
   vsg_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////
   // set/clear pulse: clear at end match, set at start match
   function automatic logic pulse_step(input logic                cur,
                                       input logic [vsg_pkg::CNT_W-1:0] cnt,
                                       input logic [vsg_pkg::CNT_W-1:0] set_at,
                                       input logic [vsg_pkg::CNT_W-1:0] clr_at);
      logic v;
      v = cur;
      if (cnt == clr_at) begin
         v = 1'b0;
      end
      if (cnt == set_at) begin
         v = 1'b1;
      end
      return v;
   endfunction

   function automatic logic [vsg_pkg::CNT_W-1:0] wide(input logic [vsg_pkg::REG_W-1:0] x);
      return {1'b0, x};
   endfunction

   function automatic logic polar(input logic act, input logic high_true);
      return high_true ? act : ~act;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [vsg_pkg::REG_W-1:0] st;
   logic [vsg_pkg::REG_W-1:0] clocks_per_line_total;
   logic [vsg_pkg::REG_W-1:0] hhalf;
   logic [vsg_pkg::REG_W-1:0] hc;
   logic [vsg_pkg::REG_W-1:0] hp;
   logic [vsg_pkg::CNT_W-1:0] lines_per_frame_total;
   logic [vsg_pkg::CNT_W-1:0] vc;
   logic                      interlaced;
   logic                      double_rate;
   logic                      blank_edge;
   logic                      sync_edge;
   logic                      load_fall;
   logic                      load_rise;
   logic                      csync;
   logic                      cblank;
   logic                      cursor;
   logic                      hsel;
   logic                      vsel;

   always_comb begin
      s_nxt = s_r;
      st    = s_r.regs[vsg_pkg::ADR_STATUS];
      clocks_per_line_total  = s_r.regs[vsg_pkg::ADR_H_TOTAL];
      hhalf = {1'b0, clocks_per_line_total[vsg_pkg::REG_W-1:1]};
      interlaced  = (st[vsg_pkg::ST_MODE_HI:vsg_pkg::ST_MODE_LO] == 2'b00);
      double_rate = (st[vsg_pkg::ST_MODE_HI:vsg_pkg::ST_MODE_LO] != 2'b11);
      lines_per_frame_total  = interlaced ? {s_r.regs[vsg_pkg::ADR_V_TOTAL], 1'b0}
                         : wide(s_r.regs[vsg_pkg::ADR_V_TOTAL]);
      hc = 12'h000;
      hp = 12'h000;
      vc = s_r.vcnt;
      blank_edge = 1'b0;
      sync_edge  = 1'b0;
      load_fall  = 1'b0;
      load_rise  = 1'b0;
      csync  = 1'b0;
      cblank = 1'b0;
      cursor = 1'b0;
      hsel   = 1'b0;
      vsel   = 1'b0;

      if (CLK_EN) begin
         ///////////////////////////////////////////////////////////////////
         // load port synchronisers
         s_nxt.sy.load = {s_r.sy.load[0], LOAD};
         s_nxt.sy.ad   = {s_r.sy.ad[0], ADDR_OR_DATA_SELECT};
         s_nxt.sy.bh   = {s_r.sy.bh[0], BYTE_HALF_SELECT};
         s_nxt.sy.d1   = DATA;
         s_nxt.sy.d2   = s_r.sy.d1;
         // edges taken behind the second stage only
         s_nxt.load_q  = s_r.sy.load[1];
         load_fall = s_r.load_q && !s_r.sy.load[1];
         load_rise = !s_r.load_q && s_r.sy.load[1];

         if (load_fall) begin
            s_nxt.ad_lat = s_r.sy.ad[1];
            s_nxt.bh_lat = s_r.sy.bh[1];
            if (!s_r.sy.ad[1]) begin
               s_nxt.auto_on = s_r.sy.bh[1];
            end
         end

         if (load_rise) begin
            if (!s_r.ad_lat) begin
               s_nxt.addr  = s_r.sy.d2[vsg_pkg::ADDR_W-1:0];
               s_nxt.start = s_r.sy.d2[vsg_pkg::ADDR_W-1:0];
            end else begin
               if (s_r.addr <= vsg_pkg::ADR_LAST) begin
                  if (s_r.bh_lat) begin
                     s_nxt.regs[s_r.addr][11:8] = s_r.sy.d2[3:0];
                  end else begin
                     s_nxt.regs[s_r.addr][7:0] = s_r.sy.d2;
                  end
               end
               if (s_r.auto_on && s_r.bh_lat) begin
                  if (s_r.addr >= vsg_pkg::ADR_LAST) begin
                     s_nxt.addr = s_r.start;
                  end else begin
                     s_nxt.addr = s_r.addr + 6'h01;
                  end
               end
            end
         end

         ///////////////////////////////////////////////////////////////////
         // raster counters, run only while the status run bit is set
         if (st[vsg_pkg::ST_RUN]) begin
            hc = (s_r.hcnt >= clocks_per_line_total) ? 12'h001 : s_r.hcnt + 12'h001;
            s_nxt.hcnt = hc;
            hp = (double_rate && hc > hhalf) ? hc - hhalf : hc;
            blank_edge = (hc == 12'h001) ||
                         (interlaced && hc == hhalf + 12'h001);
            sync_edge  = (hc == s_r.regs[vsg_pkg::ADR_H_FRONT]) ||
                         (interlaced &&
                          hc == hhalf + s_r.regs[vsg_pkg::ADR_H_FRONT]);
            if ((interlaced && blank_edge) || hc == 12'h001) begin
               vc = (s_r.vcnt >= lines_per_frame_total) ? 13'h0001 : s_r.vcnt + 13'h0001;
               s_nxt.vcnt = vc;
            end

            // horizontal pulses
            s_nxt.p.h_blank = pulse_step(s_r.p.h_blank, wide(hc), 13'h0001,
                                         wide(s_r.regs[vsg_pkg::ADR_H_BLANK_END]));
            s_nxt.p.h_sync  = pulse_step(s_r.p.h_sync, wide(hc),
                                         wide(s_r.regs[vsg_pkg::ADR_H_FRONT]),
                                         wide(s_r.regs[vsg_pkg::ADR_H_SYNC_END]));
            s_nxt.p.h_gate  = pulse_step(s_r.p.h_gate, wide(hc),
                                         wide(s_r.regs[vsg_pkg::ADR_CUR_H_START]),
                                         wide(s_r.regs[vsg_pkg::ADR_CUR_H_END]));
            s_nxt.p.eq      = pulse_step(s_r.p.eq, wide(hp),
                                         wide(s_r.regs[vsg_pkg::ADR_H_FRONT]),
                                         wide(s_r.regs[vsg_pkg::ADR_EQ_END]));
            s_nxt.p.serr    = pulse_step(s_r.p.serr, wide(hp),
                                         wide(s_r.regs[vsg_pkg::ADR_SERR_END]),
                                         wide(s_r.regs[vsg_pkg::ADR_H_FRONT]));

            // vertical pulses move with horizontal blank leading edge
            if (blank_edge) begin
               s_nxt.p.v_blank = pulse_step(s_r.p.v_blank, vc, 13'h0001,
                                            wide(s_r.regs[vsg_pkg::ADR_V_BLANK_END]));
               s_nxt.p.v_int   = pulse_step(s_r.p.v_int, vc,
                                            wide(s_r.regs[vsg_pkg::ADR_VINT_ON]),
                                            wide(s_r.regs[vsg_pkg::ADR_VINT_OFF]));
               s_nxt.p.v_gate  = pulse_step(s_r.p.v_gate, vc,
                                            wide(s_r.regs[vsg_pkg::ADR_CUR_V_START]),
                                            wide(s_r.regs[vsg_pkg::ADR_CUR_V_END]));
               s_nxt.p.es_win  = pulse_step(s_r.p.es_win, vc,
                                            wide(s_r.regs[vsg_pkg::ADR_ES_WIN_START]),
                                            wide(s_r.regs[vsg_pkg::ADR_ES_WIN_END]));
            end
            // vertical sync moves with horizontal sync leading edge
            if (sync_edge) begin
               s_nxt.p.v_sync = pulse_step(s_r.p.v_sync, vc,
                                           wide(s_r.regs[vsg_pkg::ADR_V_FRONT]),
                                           wide(s_r.regs[vsg_pkg::ADR_V_SYNC_END]));
            end
         end

         ///////////////////////////////////////////////////////////////////
         // composite forming and output selection
         cblank = s_r.p.h_blank | s_r.p.v_blank;
         if (s_r.p.es_win && !st[vsg_pkg::ST_ES_OFF]) begin
            csync = s_r.p.v_sync ? s_r.p.serr : s_r.p.eq;
         end else begin
            csync = s_r.p.h_sync | s_r.p.v_sync;
         end
         cursor = s_r.p.h_gate & s_r.p.v_gate;

         if (st[vsg_pkg::ST_SEL_V_BLANK]) begin
            hsel = s_r.p.h_blank;
         end else if (st[vsg_pkg::ST_SEL_CURSOR]) begin
            hsel = cursor;
         end else begin
            hsel = s_r.p.h_gate;
         end
         if (st[vsg_pkg::ST_SEL_V_SYNC]) begin
            vsel = s_r.p.h_sync;
         end else if (st[vsg_pkg::ST_SEL_CURSOR]) begin
            vsel = s_r.p.v_int;
         end else begin
            vsel = s_r.p.v_gate;
         end

         s_nxt.o.blank = polar(st[vsg_pkg::ST_SEL_V_BLANK] ? s_r.p.v_blank : cblank,
                               st[vsg_pkg::ST_POL_BLANK]);
         s_nxt.o.sync  = polar(st[vsg_pkg::ST_SEL_V_SYNC] ? s_r.p.v_sync : csync,
                               st[vsg_pkg::ST_POL_SYNC]);
         s_nxt.o.haux  = polar(hsel, st[vsg_pkg::ST_POL_HAUX]);
         s_nxt.o.vaux  = polar(vsel, st[vsg_pkg::ST_POL_VAUX]);
         s_nxt.o.odd   = interlaced ? (s_r.vcnt <= wide(s_r.regs[vsg_pkg::ADR_V_TOTAL]))
                                    : 1'b1;
      end

      if (RESET) begin
         s_nxt         = '0;
         s_nxt.regs    = {vsg_pkg::NUM_REGS{vsg_pkg::DATA_RST}};
         s_nxt.regs[vsg_pkg::ADR_STATUS] = vsg_pkg::STATUS_RST;
         s_nxt.hcnt    = vsg_pkg::DATA_RST;
         s_nxt.vcnt    = vsg_pkg::CNT_RST;
         s_nxt.sy.load = 2'b11;
         s_nxt.load_q  = 1'b1;
         s_nxt.o       = vsg_pkg::OUT_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // all state on falling clock edge
   always_ff @(negedge CLOCK) begin
      s_r <= s_nxt;
   end

   always_comb begin
      BLANK_OUT     = s_r.o.blank;
      SYNC_OUT      = s_r.o.sync;
      HORIZ_AUX_OUT = s_r.o.haux;
      VERT_AUX_OUT  = s_r.o.vaux;
      FIELD_ODD_OUT = s_r.o.odd;
   end

endmodule

`default_nettype wire

// File: bench/vsg_timing_checker.sv
// Purpose: port-level timing assertions for the sync generator
// Assumes: status written with manual addressing, non-interlaced
// Notes:   timing relations checked in separate mode, high polarity
`timescale 1ns/1ps
`default_nettype none

module vsg_timing_checker (
   // clock and reset
   input wire logic       CLOCK,
   input wire logic       RESET,
   input wire logic       CLK_EN,
   // load port
   input wire logic       LOAD,
   input wire logic       ADDR_OR_DATA_SELECT,
   input wire logic       BYTE_HALF_SELECT,
   input wire logic [7:0] DATA,
   // video outputs
   input wire logic       BLANK_OUT,
   input wire logic       SYNC_OUT,
   input wire logic       HORIZ_AUX_OUT,
   input wire logic       VERT_AUX_OUT,
   input wire logic       FIELD_ODD_OUT
);
   localparam int H_TOT = 20, H_BL_END = 9, H_FP = 3;
   localparam int V_TOT = 10, V_BL_END = 5, V_FP = 2, V_SE = 4;
   logic [11:0] st_r;
   logic [5:0]  adr_r;
   logic        ad_r;
   logic        bh_r;
   logic [7:0]  quiet_r, hs_r, vs_r;
   logic        sep;

   ////////////////////////////////////////////////////////////
   // shadow of the status register
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         st_r    <= 12'h000;
         adr_r   <= 6'h00;
         quiet_r <= 8'h00;
      end else begin
         if ($fell(LOAD)) begin
            ad_r <= ADDR_OR_DATA_SELECT;
            bh_r <= BYTE_HALF_SELECT;
         end
         if ($rose(LOAD) && !ad_r) adr_r <= DATA[5:0];
         if ($rose(LOAD) && ad_r && adr_r == 6'h00 && !bh_r) st_r[7:0] <= DATA;
         if ($rose(LOAD) && ad_r && adr_r == 6'h00 && bh_r) st_r[11:8] <= DATA[3:0];
         quiet_r <= (!LOAD || !CLK_EN) ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hff};
      end
   end

   // clocks since line start, lines since frame start
   always_ff @(posedge CLOCK) begin
      hs_r <= $rose(HORIZ_AUX_OUT) ? 8'h01 : hs_r + 8'h01;
      if ($rose(BLANK_OUT)) vs_r <= 8'h01;
      else if ($rose(HORIZ_AUX_OUT)) vs_r <= vs_r + 8'h01;
   end
   assign sep = st_r == 12'h7ff && quiet_r == 8'hff;

   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   line_period_a: assert property (sep && $rose(HORIZ_AUX_OUT) |-> hs_r == H_TOT)
      else $error("line period wrong");
   horiz_blank_out_width_a: assert property (sep && $fell(HORIZ_AUX_OUT) |-> hs_r == H_BL_END - 1)
      else $error("horizontal blank width wrong");
   front_porch_a: assert property (sep && $rose(VERT_AUX_OUT) |-> hs_r == H_FP - 1)
      else $error("front porch wrong");
   hsync_width_a: assert property (sep && $rose(VERT_AUX_OUT) |-> VERT_AUX_OUT [*3] ##1 !VERT_AUX_OUT)
      else $error("horizontal sync width wrong");
   vert_blank_out_edge_a: assert property (sep && $changed(BLANK_OUT) |-> $rose(HORIZ_AUX_OUT))
      else $error("vertical blank moved off line start");
   vsync_edge_a: assert property (sep && $changed(SYNC_OUT) |-> $rose(VERT_AUX_OUT))
      else $error("vertical sync moved off sync start");
   frame_period_a: assert property (sep && $rose(BLANK_OUT) |-> vs_r == V_TOT)
      else $error("frame period wrong");
   vert_blank_out_width_a: assert property (sep && $fell(BLANK_OUT) |-> vs_r == V_BL_END - 1)
      else $error("vertical blank width wrong");
   vsync_start_a: assert property (sep && $rose(SYNC_OUT) |-> vs_r == V_FP)
      else $error("vertical sync start wrong");
   vsync_end_a: assert property (sep && $fell(SYNC_OUT) |-> vs_r == V_SE)
      else $error("vertical sync end wrong");
   sep_frame_c: cover property (sep && $rose(BLANK_OUT));
   sep_vsync_c: cover property (sep && $fell(SYNC_OUT));
   data_load_c: cover property ($rose(LOAD) && ad_r);
endmodule

bind vsg_timing vsg_timing_checker chk_u (
   .CLOCK(CLOCK), .RESET(RESET), .CLK_EN(CLK_EN), .LOAD(LOAD),
   .ADDR_OR_DATA_SELECT(ADDR_OR_DATA_SELECT), .BYTE_HALF_SELECT(BYTE_HALF_SELECT),
   .DATA(DATA), .BLANK_OUT(BLANK_OUT), .SYNC_OUT(SYNC_OUT),
   .HORIZ_AUX_OUT(HORIZ_AUX_OUT), .VERT_AUX_OUT(VERT_AUX_OUT), .FIELD_ODD_OUT(FIELD_ODD_OUT));
`default_nettype wire

// File: bench/vsg_host_model.sv
// Purpose: host side of the byte-wide register load port
// Assumes: load phases of four clocks clear the synchroniser
// Notes:   data lines show the inverted byte once released
`timescale 1ns/1ps
`default_nettype none

module vsg_host_model (
   // clock
   input wire logic       CLOCK,
   // load port
   output var logic       LOAD,
   output var logic       ADDR_OR_DATA_SELECT,
   output var logic       BYTE_HALF_SELECT,
   output var logic [7:0] DATA
);
   initial begin
      LOAD = 1'b1;
      ADDR_OR_DATA_SELECT = 1'b1;
      BYTE_HALF_SELECT = 1'b0;
      DATA = 8'h00;
   end

   ////////////////////////////////////////////////////////////
   // one load cycle: selects taken at the fall, byte at the rise
   task automatic ld(input logic ad, input logic bh, input logic [7:0] d);
      ADDR_OR_DATA_SELECT <= ad;
      BYTE_HALF_SELECT    <= bh;
      DATA                <= d;
      repeat (3) @(posedge CLOCK);
      LOAD <= 1'b0;
      repeat (4) @(posedge CLOCK);
      LOAD <= 1'b1;
      repeat (4) @(posedge CLOCK);
      DATA <= ~d;
      @(posedge CLOCK);
   endtask

   // low byte, then high byte into bits 11:8
   task automatic wr_pair(input logic [11:0] v);
      ld(1'b1, 1'b0, v[7:0]);
      ld(1'b1, 1'b1, {4'h0, v[11:8]});
   endtask

   task automatic wr_man(input logic [5:0] a, input logic [11:0] v);
      ld(1'b0, 1'b0, {2'b00, a});
      wr_pair(v);
   endtask
endmodule
`default_nettype wire

// File: bench/tb_programmable_video_sync_timing.sv
// Purpose: self-checking bench for the sync timing generator
// Assumes: non-interlaced, single and double serration modes
// Notes:   output pattern predicted per clock from programmed counts
`timescale 1ns/1ps
`default_nettype none

module tb_programmable_video_sync_timing;
   logic        clock, reset, clk_en, pb;
   wire  [4:0]  outs;
   wire  [7:0]  data;
   wire         load, ad_sel, bh_sel;
   logic [4:0]  snap;
   logic [11:0] regs [1:18];
   int          fails, cmp_count, cyc, base;

   vsg_timing dut_u (
      .CLOCK(clock), .RESET(reset), .CLK_EN(clk_en), .LOAD(load),
      .ADDR_OR_DATA_SELECT(ad_sel), .BYTE_HALF_SELECT(bh_sel), .DATA(data),
      .BLANK_OUT(outs[4]), .SYNC_OUT(outs[3]), .HORIZ_AUX_OUT(outs[2]),
      .VERT_AUX_OUT(outs[1]), .FIELD_ODD_OUT(outs[0]));
   vsg_host_model host_u (
      .CLOCK(clock), .LOAD(load), .ADDR_OR_DATA_SELECT(ad_sel),
      .BYTE_HALF_SELECT(bh_sel), .DATA(data));

   always #4 clock = ~clock;

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fails++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [4:0] got, input logic [4:0] want);
      cmp_count++;
      if (got !== want) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, want, got);
      end
   endtask

   task automatic give_verdict();
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // write status, then predict one frame clock by clock
   task automatic run_mode(input logic [11:0] st);
      int p, h, ln, hq;
      logic hb, hs, vb, vs, hg, vg, vi, es, eq, se;
      logic [4:0] want;
      host_u.wr_man(6'h00, st);
      repeat (20) @(posedge clock);
      repeat (200) begin
         @(posedge clock);
         p  = (cyc - base) % 200;
         h  = p % 20 + 1;
         ln = p / 20 + 1;
         hb = h < 9;
         hs = h >= 3 && h < 6;
         vb = ln < 5;
         vs = (ln == 2 && h >= 3) || ln == 3 || (ln == 4 && h < 3);
         hg = h >= 4 && h < 7;
         vg = ln == 2;
         vi = ln == 6 || ln == 7;
         // half-line position in double mode, window lines 1..5
         hq = (st[4:3] != 2'b11 && h > 10) ? h - 10 : h;
         es = ln < 6 && !st[9];
         eq = hq >= 3 && hq < 5;
         se = hq >= 8 || hq < 3;
         want[4] = st[0] ? vb : vb | hb;
         want[3] = st[1] ? vs : es ? (vs ? se : eq) : vs | hs;
         want[2] = st[0] ? hb : st[2] ? hg & vg : hg;
         want[1] = st[1] ? hs : st[2] ? vi : vg;
         want[0] = 1'b1;
         check("outputs", outs, want ^ {~st[5], ~st[6], ~st[7], ~st[8], 1'b0});
      end
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      reset = 1'b1;
      clk_en = 1'b1;
      fails = 0;
      cmp_count = 0;
      cyc = 0;
      base = 0;
      // even line total, ends as width plus one, whole-line frame
      regs = '{12'h003, 12'h006, 12'h009, 12'h014, 12'h002, 12'h004,
               12'h005, 12'h00a, 12'h005, 12'h008, 12'h001, 12'h006,
               12'h006, 12'h008, 12'h004, 12'h007, 12'h002, 12'h003};
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      check("reset", outs, vsg_pkg::OUT_RST);
      host_u.ld(1'b0, 1'b1, 8'h01);
      for (int i = 1; i <= 18; i++) host_u.wr_pair(i == 1 ? 12'h001 : regs[i]);
      host_u.wr_pair(regs[1]);
      check("stopped", outs, vsg_pkg::OUT_RST);
      host_u.wr_man(6'h00, 12'h7ff);
      repeat (20) @(posedge clock);
      pb = outs[4];
      repeat (300) begin
         @(posedge clock);
         if (outs[4] === 1'b1 && pb === 1'b0) break;
         pb = outs[4];
      end
      base = cyc;
      for (int m = 0; m < 8; m++) run_mode(12'h618 | (m[0] ? 12'h1e0 : 12'h000) | m[2:0]);
      run_mode(12'h5f8);
      run_mode(12'h5e8);
      clk_en <= 1'b0;
      @(posedge clock);
      snap = outs;
      repeat (49) begin
         @(posedge clock);
         check("frozen", outs, snap);
      end
      clk_en <= 1'b1;
      base = base + 50;
      run_mode(12'h7ff);
      repeat (600) @(posedge clock);
      give_verdict();
   end
endmodule
`default_nettype wire
